// ===== core/channel_power_seq.sv
// Module: power-up and power-down sequencer for one record channel
`timescale 1ns/10ps
module channel_power_seq (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Request and state
  input wire logic i_power_req,
  output logic o_power_on,
  output logic o_powered_up
);
  rec_pwr_pkg::ch_state_t state_ff;
  logic [rec_pwr_pkg::CNT_W-1:0] cnt_ff;

  localparam logic [rec_pwr_pkg::CNT_W-1:0] SETTLE_LAST =
    rec_pwr_pkg::CNT_W'(rec_pwr_pkg::SETTLE_CYC - 1);

  // Power is applied during ramp-up and on; status rises only when settled
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= rec_pwr_pkg::CH_OFF;
      cnt_ff <= '0;
    end else if (i_ce) begin
      case (state_ff)
        rec_pwr_pkg::CH_OFF: begin
          cnt_ff <= '0;
          if (i_power_req) state_ff <= rec_pwr_pkg::CH_RAMP_UP;
        end
        rec_pwr_pkg::CH_RAMP_UP: begin
          if (!i_power_req) begin
            state_ff <= rec_pwr_pkg::CH_RAMP_DOWN;
            cnt_ff <= '0;
          end else if (cnt_ff == SETTLE_LAST) begin
            state_ff <= rec_pwr_pkg::CH_ON;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        rec_pwr_pkg::CH_ON: begin
          cnt_ff <= '0;
          if (!i_power_req) state_ff <= rec_pwr_pkg::CH_RAMP_DOWN;
        end
        default: begin
          // Ramp-down always completes before a new power-up, so the
          // analog block never sees a half-discharged restart
          if (cnt_ff == SETTLE_LAST) begin
            state_ff <= rec_pwr_pkg::CH_OFF;
            cnt_ff <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      endcase
    end
  end

  assign o_power_on = (state_ff == rec_pwr_pkg::CH_RAMP_UP) || (state_ff == rec_pwr_pkg::CH_ON);
  assign o_powered_up = (state_ff == rec_pwr_pkg::CH_ON);
endmodule // channel_power_seq

// ===== core/rec_pwr_pkg.sv
// Package: register map, field positions and timing for record channel power control
package rec_pwr_pkg;
  // Register offsets on the control port (channel enable offset from the register map)
  localparam logic [7:0] OFS_CHANNEL_ENABLE = 8'h76;
  localparam logic [7:0] OFS_DYNAMIC_POWER_CONFIG = 8'h77;
  localparam logic [7:0] OFS_POWER_CONFIG = 8'h78;
  localparam logic [7:0] OFS_CHANNEL_POWER_STATUS = 8'h79;

  // Reset values
  localparam logic [7:0] RST_CHANNEL_ENABLE = 8'hCC;
  localparam logic [7:0] RST_DYNAMIC_POWER_CONFIG = 8'h00;
  localparam logic [7:0] RST_POWER_CONFIG = 8'h00;

  // Field positions
  localparam int CHEN_LSB = 4;
  localparam int DYN_EN_BIT = 7;
  localparam int DYN_LIMIT_BIT = 6;
  localparam int DYN_SPLIT_BIT = 3;
  localparam int MASTER_BIT = 7;
  localparam int BIAS_BIT = 5;
  localparam int ULTRA_BIT = 3;
  localparam int VOICE_BIT = 2;
  localparam int NUM_CH = 4;

  // Writable masks: reserved read-only bits stay zero
  localparam logic [7:0] DYN_WR_MASK = 8'hF8;
  localparam logic [7:0] PWR_WR_MASK = 8'hEE;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] LOW_CH_MASK = 4'hC;
  localparam logic [3:0] ALL_CH_MASK = 4'hF;

  // Channel power sequencing time
  localparam int SETTLE_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [1:0] {
    CH_OFF,
    CH_RAMP_UP,
    CH_ON,
    CH_RAMP_DOWN
  } ch_state_t;

  // Register write request from the control port
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Analog power controls driven to the record path
  typedef struct packed {
    logic [3:0] channel_power;
    logic bias_generator_power;
    logic ultrasound_detect_enable;
    logic voice_detect_enable;
    logic dynamic_split_clock_select;
  } pwr_ctrl_t;
endpackage

// ===== core/record_channel_power_control.sv
// Module: record path channel enable, power configuration and power status registers
`timescale 1ns/10ps

// Function
// - Bits 7..4 of channel enable are per-channel enables, 1 and 2 on and 3 and 4 off at reset.
// - With dynamic power enable set, each channel powers up or down alone while others record.
// - With dynamic power enable clear, channel power states do not change while any records.
// - Dynamic limit select clear allows dynamic control of channels 1-2, set of channels 1-4.
// - Bit 3 of dynamic config selects same or split modulator and microphone clocks.
// - Bits 2..0 of dynamic config are read-only and zero.
// - Master record power set powers up every enabled channel and no other; while recording, a channel its mode does not let move keeps its state.
// - Master record power clear powers all channels down, and it is clear at reset.
// - Bias power bit 5 powers the bias generator up when set, default off.
// - Power config bit 3 enables ultrasound activity detection, default off.
// - Power config bit 2 enables voice activity detection, default off.
// - Status bits 7..4 show each channel's actual power state, zero at reset.
module record_channel_power_control (
  // Clock, reset, clock enable
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Control port register access
  input wire rec_pwr_pkg::reg_req_t i_req,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Record path power controls
  output rec_pwr_pkg::pwr_ctrl_t o_pwr_ctrl
);
  logic [7:0] chen_ff;
  logic [7:0] dyn_ff;
  logic [7:0] pwr_ff;
  logic [3:0] req_ff;
  logic [3:0] nxt_req;
  logic [3:0] seq_on;
  logic [3:0] seq_up;
  logic [3:0] status_ff;
  logic [7:0] rd_data_ff;
  logic rd_valid_ff;
  rec_pwr_pkg::pwr_ctrl_t ctrl_ff;

  // Address match shared by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Channel enable register; low nibble is stored as written, host keeps it at reset value
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chen_ff <= rec_pwr_pkg::RST_CHANNEL_ENABLE;
    end else if (i_ce && i_req.wr_en && hit(i_req.addr, rec_pwr_pkg::OFS_CHANNEL_ENABLE)) begin
      chen_ff <= i_req.wdata;
    end
  end

  // Dynamic power configuration; bits 2..0 cannot be written
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dyn_ff <= rec_pwr_pkg::RST_DYNAMIC_POWER_CONFIG;
    end else if (i_ce && i_req.wr_en &&
                 hit(i_req.addr, rec_pwr_pkg::OFS_DYNAMIC_POWER_CONFIG)) begin
      dyn_ff <= i_req.wdata & rec_pwr_pkg::DYN_WR_MASK;
    end
  end

  // Power configuration; read-only reserved bits 4 and 0 stay zero
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pwr_ff <= rec_pwr_pkg::RST_POWER_CONFIG;
    end else if (i_ce && i_req.wr_en && hit(i_req.addr, rec_pwr_pkg::OFS_POWER_CONFIG)) begin
      pwr_ff <= i_req.wdata & rec_pwr_pkg::PWR_WR_MASK;
    end
  end

  // Per-channel power request.
  // Master off drops every channel at once. When master is on, a channel
  // follows its enable only if it may move: in dynamic mode within the
  // limited channel set, otherwise only while nothing is recording. A
  // channel outside the allowed set keeps its request until recording stops.
  always_comb begin
    logic [3:0] en_ch;
    logic [3:0] movable;
    logic any_rec;
    en_ch = '0;
    movable = '0;
    any_rec = |seq_on;
    nxt_req = req_ff;
    for (int i = 0; i < rec_pwr_pkg::NUM_CH; i++) begin
      en_ch[i] = chen_ff[rec_pwr_pkg::CHEN_LSB + rec_pwr_pkg::NUM_CH - 1 - i];
    end
    if (!any_rec) begin
      movable = rec_pwr_pkg::ALL_CH_MASK;
    end else if (dyn_ff[rec_pwr_pkg::DYN_EN_BIT]) begin
      movable = dyn_ff[rec_pwr_pkg::DYN_LIMIT_BIT] ? rec_pwr_pkg::ALL_CH_MASK
                                                   : rec_pwr_pkg::LOW_CH_MASK >>
                                                     (rec_pwr_pkg::NUM_CH / 2);
    end
    if (!pwr_ff[rec_pwr_pkg::MASTER_BIT]) begin
      nxt_req = '0;
    end else begin
      for (int i = 0; i < rec_pwr_pkg::NUM_CH; i++) begin
        if (movable[i]) nxt_req[i] = en_ch[i];
      end
    end
  end

  // Request register, bit 0 is channel 1
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_ff <= '0;
    end else if (i_ce) begin
      req_ff <= nxt_req;
    end
  end

  // One sequencer per channel
  for (genvar g = 0; g < rec_pwr_pkg::NUM_CH; g++) begin : g_ch
    channel_power_seq u_seq (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_power_req(req_ff[g]),
      .o_power_on(seq_on[g]),
      .o_powered_up(seq_up[g])
    );
  end

  // Power status follows completed sequencing
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_ff <= '0;
    end else if (i_ce) begin
      status_ff <= seq_up;
    end
  end

  // Analog controls, registered so outputs come from flip-flops
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_ff <= '0;
    end else if (i_ce) begin
      ctrl_ff.channel_power <= seq_on;
      ctrl_ff.bias_generator_power <= pwr_ff[rec_pwr_pkg::BIAS_BIT];
      ctrl_ff.ultrasound_detect_enable <= pwr_ff[rec_pwr_pkg::ULTRA_BIT];
      ctrl_ff.voice_detect_enable <= pwr_ff[rec_pwr_pkg::VOICE_BIT];
      ctrl_ff.dynamic_split_clock_select <= dyn_ff[rec_pwr_pkg::DYN_SPLIT_BIT];
    end
  end

  // Read port: one-cycle latency, unmapped offsets read zero
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_data_ff <= rec_pwr_pkg::ZERO_BYTE;
      rd_valid_ff <= 1'b0;
    end else if (i_ce) begin
      rd_valid_ff <= i_rd_en;
      if (!i_rd_en) begin
        rd_data_ff <= rec_pwr_pkg::ZERO_BYTE;
      end else if (hit(i_rd_addr, rec_pwr_pkg::OFS_CHANNEL_ENABLE)) begin
        rd_data_ff <= chen_ff;
      end else if (hit(i_rd_addr, rec_pwr_pkg::OFS_DYNAMIC_POWER_CONFIG)) begin
        rd_data_ff <= dyn_ff;
      end else if (hit(i_rd_addr, rec_pwr_pkg::OFS_POWER_CONFIG)) begin
        rd_data_ff <= pwr_ff;
      end else if (hit(i_rd_addr, rec_pwr_pkg::OFS_CHANNEL_POWER_STATUS)) begin
        rd_data_ff <= {status_ff[0], status_ff[1], status_ff[2], status_ff[3], 4'h0};
      end else begin
        rd_data_ff <= rec_pwr_pkg::ZERO_BYTE;
      end
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_pwr_ctrl = ctrl_ff;
endmodule // record_channel_power_control

// ===== tb/host_model.sv
// Host controller model: single register writes and reads on the control port
`timescale 1ns/10ps
module host_model (
  // Clock
  input wire logic i_sys_clk,
  // Control port
  output rec_pwr_pkg::reg_req_t o_req,
  output logic o_rd_en,
  output logic [7:0] o_rd_addr
);
  initial begin
    o_req = '0;
    o_rd_en = 1'b0;
    o_rd_addr = 8'h00;
  end
  // Strobe is up for one taken edge; released lines show the inverse, never stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_req <= '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge i_sys_clk);
    o_req <= '{wr_en: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    o_rd_en <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_sys_clk);
    o_rd_en <= 1'b0;
    o_rd_addr <= ~a;
  endtask
endmodule // host_model

// ===== tb/rec_pwr_monitor.sv
// Checker: register port and record power control assertions
`timescale 1ns/10ps
module rec_pwr_monitor (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire rec_pwr_pkg::reg_req_t i_req,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire rec_pwr_pkg::pwr_ctrl_t o_pwr_ctrl
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic [8:0] on_cnt_ff;
  logic [7:0] ra_ff;
  logic wr_dyn;
  logic wr_pwr;
  assign wr_dyn = i_ce && i_req.wr_en && i_req.addr == 8'h77;
  assign wr_pwr = i_ce && i_req.wr_en && i_req.addr == 8'h78;
  // Cycles channel 1 has had power, and the last read address, for the status checks
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) on_cnt_ff <= 9'h000;
    else if (!o_pwr_ctrl.channel_power[0]) on_cnt_ff <= 9'h000;
    else if (on_cnt_ff != 9'h1FF) on_cnt_ff <= on_cnt_ff + 9'h001;
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) ra_ff <= 8'h00;
    else if (i_ce && i_rd_en) ra_ff <= i_rd_addr;
  end
  property p_rd_valid; i_ce && i_rd_en |=> o_rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read unanswered");
  property p_sts_low; o_rd_valid && ra_ff == 8'h79 |-> o_rd_data[3:0] == 4'h0; endproperty
  a_sts_low: assert property (p_sts_low) else $error("status low nibble set");
  property p_dyn_ro; o_rd_valid && ra_ff == 8'h77 |-> o_rd_data[2:0] == 3'h0; endproperty
  a_dyn_ro: assert property (p_dyn_ro) else $error("dynamic low bits set");
  // Written value is taken two samples back, so no local variable is needed
  property p_bias;
    wr_pwr |-> ##2 o_pwr_ctrl.bias_generator_power == $past(i_req.wdata[5], 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bias power wrong");
  property p_detect;
    wr_pwr |-> ##2 {o_pwr_ctrl.ultrasound_detect_enable, o_pwr_ctrl.voice_detect_enable} ==
      $past(i_req.wdata[3:2], 2);
  endproperty
  a_detect: assert property (p_detect) else $error("detect enable wrong");
  property p_split;
    wr_dyn |-> ##2 o_pwr_ctrl.dynamic_split_clock_select == $past(i_req.wdata[3], 2);
  endproperty
  a_split: assert property (p_split) else $error("clock split wrong");
  property p_off; wr_pwr && !i_req.wdata[7] |-> ##4 o_pwr_ctrl.channel_power == 4'h0; endproperty
  a_off: assert property (p_off) else $error("channels still powered");
  property p_rst; $rose(i_nrst) |-> o_pwr_ctrl == '0; endproperty
  a_rst: assert property (p_rst) else $error("power on after reset");
  // Status may only show channel 1 up once its power has been on for at least 240 cycles
  property p_ramp; o_rd_valid && ra_ff == 8'h79 && o_rd_data[7] && o_pwr_ctrl.channel_power[0]
    |-> on_cnt_ff >= 9'h0F0; endproperty
  a_ramp: assert property (p_ramp) else $error("status before ramp done");
  c_three: cover property (o_pwr_ctrl.channel_power == 4'h7);
  c_sts: cover property (o_rd_valid && ra_ff == 8'h79 && o_rd_data == 8'hE0);
  c_bias: cover property ($rose(o_pwr_ctrl.bias_generator_power));
endmodule // rec_pwr_monitor

bind record_channel_power_control rec_pwr_monitor i_rec_pwr_monitor (.i_sys_clk, .i_nrst,
  .i_ce, .i_req, .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_valid, .o_pwr_ctrl);

// ===== tb/tb_top.sv
// Testbench: register map, access kinds and channel power sequencing
`timescale 1ns/10ps
module tb_top;
  logic i_sys_clk;
  logic i_nrst;
  logic i_ce;
  rec_pwr_pkg::reg_req_t req;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_valid;
  rec_pwr_pkg::pwr_ctrl_t pwr;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  int n_mismatch;
  int total_checks;
  host_model i_host_model (.i_sys_clk(i_sys_clk), .o_req(req), .o_rd_en(rd_en),
    .o_rd_addr(rd_addr));
  record_channel_power_control i_record_channel_power_control (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_ce(i_ce), .i_req(req), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_pwr_ctrl(pwr));
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // Each answered read takes the oldest expectation off the queue
  always @(posedge i_sys_clk) begin
    if (rd_valid === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0 || rd_data !== exp_q[0]) begin
        n_mismatch++;
        $display("unexpected at %0t: read data %h", $time, rd_data);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host_model.rd(a);
  endtask
  // Write, let the power path settle for w cycles, then read back
  task automatic step(input logic [7:0] a, input logic [7:0] v, input int w,
                      input logic [7:0] ra, input logic [7:0] e);
    i_host_model.wr(a, v);
    repeat (w) @(posedge i_sys_clk);
    rd(ra, e);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog: the whole sequence needs about 2000 cycles
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_mismatch++;
    results();
  end
  initial begin
    i_nrst = 1'b0;
    i_ce = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(32'h4A4F));
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rd(8'h76, 8'hCC);
    rd(8'h77, 8'h00);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    rd(8'h5A, 8'h00);
    $display("test reset values done");
    step(8'h77, 8'h80, 1, 8'h77, 8'h80);
    step(8'h78, 8'h80, 260, 8'h79, 8'hC0);
    step(8'h76, 8'hEC, 260, 8'h79, 8'hC0);
    step(8'h77, 8'hC0, 1, 8'h77, 8'hC0);
    step(8'h76, 8'hEC, 260, 8'h79, 8'hE0);
    step(8'h76, 8'h6C, 260, 8'h79, 8'h60);
    step(8'h77, 8'h00, 1, 8'h77, 8'h00);
    step(8'h76, 8'hCC, 260, 8'h79, 8'h60);
    step(8'h78, 8'h00, 260, 8'h79, 8'h00);
    step(8'h79, 8'hFF, 1, 8'h79, 8'h00);
    step(8'h78, 8'hFF, 260, 8'h79, 8'hC0);
    rd(8'h78, 8'hEE);
    $display("test power sequencing done");
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom());
      step(8'h77, d, 1, 8'h77, d & 8'hF8);
      step(8'h76, {d[7:4], 4'hC}, 1, 8'h76, {d[7:4], 4'hC});
    end
    $display("test random access done");
    // Clock enable low: a write offered then must not land
    repeat (4) @(posedge i_sys_clk);
    i_ce <= 1'b0;
    i_host_model.wr(8'h78, 8'h00);
    @(posedge i_sys_clk);
    i_ce <= 1'b1;
    rd(8'h78, 8'hEE);
    $display("test clock enable done");
    // Reset in mid-run with channels powered: registers return to reset values
    repeat (4) @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rd(8'h76, 8'hCC);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    $display("test mid-run reset done");
    repeat (4) @(posedge i_sys_clk);
    results();
  end
endmodule // tb_top
